// ### include/pmc_map.svh
// Register map, field positions, encodings, reset values and timing of the power mode block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PMC_IDX_PROT 6'h00
`define PMC_IDX_CTRL 6'h01
`define PMC_IDX_STATE 6'h03
`define PMC_IDX_IRQ_STAT 6'h04
`define PMC_IDX_IRQ_MASK 6'h05

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMC_RUN_MODE_SELECT_HI 6
`define PMC_RUN_MODE_SELECT_LO 5
`define PMC_RSVD_BIT 4
`define PMC_ABORT_BIT 3
`define PMC_STOP_MODE_SELECT_HI 2
`define PMC_STOP_MODE_SELECT_LO 0
`define PMC_PROT_AVLP 5
`define PMC_PROT_AVLLS 1
`define PMC_IRQ_DONE 0
`define PMC_IRQ_ABORT 1

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define PMC_RUN_NORMAL 2'h0
`define PMC_RUN_RSVD1 2'h1
`define PMC_RUN_VERY_LOW_POWER_RUN 2'h2
`define PMC_RUN_RSVD3 2'h3
`define PMC_STOP_NORMAL 3'h0
`define PMC_STOP_VLPS 3'h2
`define PMC_STOP_VLLS 3'h4
`define PMC_STATE_RUN 8'h01
`define PMC_STATE_STOP 8'h02
`define PMC_STATE_VERY_LOW_POWER_RUN 8'h04
`define PMC_PROT_RESET 8'h00
`define PMC_RUN_MODE_SELECT_RESET 2'h0
`define PMC_STOP_MODE_SELECT_RESET 3'h0
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMC_CLK_PERIOD_NS 5
`define PMC_ENTRY_NS 20
`define PMC_ENTRY_CYCLES ((`PMC_ENTRY_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

// ### include/pmc_pkg.sv
// Types shared by the power mode control block
package pmc_pkg;

   typedef enum logic [1:0] {
      PMC_SEQ_IDLE = 2'b00,
      PMC_SEQ_ENTER = 2'b01,
      PMC_SEQ_STOPPED = 2'b10
   } pmc_seq_state_type;

   typedef struct packed {
      logic start;
      logic abort;
      logic done;
      logic active;
      logic [2:0] mode;
   } pmc_seq_status_type;

endpackage

// ### logic/pmc_stop_seq.sv
// Stop mode entry sequencer driven by the core's sleep requests
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

module pmc_stop_seq
   import pmc_pkg::*;
#(
   parameter int ENTRY_CYCLES = `PMC_ENTRY_CYCLES,
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Core sleep request
   input wire logic sleep_req,
   input wire logic deep_sleep_select,
   input wire logic wake_request,
   // Configuration
   input wire logic [2:0] stop_mode_select,
   // Sequence status
   output pmc_seq_status_type seq
);

   pmc_seq_state_type state;
   logic [CNT_W-1:0] cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= PMC_SEQ_IDLE;
         cnt <= '0;
         seq <= '0;
      end else begin
         seq.start <= 1'b0;
         seq.abort <= 1'b0;
         seq.done <= 1'b0;
         case (state)
            PMC_SEQ_IDLE: begin
               // Plain sleep is not ours to sequence
               if (sleep_req && deep_sleep_select) begin
                  state <= PMC_SEQ_ENTER;
                  seq.start <= 1'b1;
                  seq.mode <= stop_mode_select;
                  cnt <= CNT_W'(ENTRY_CYCLES - 1);
               end
            end
            PMC_SEQ_ENTER: begin
               if (wake_request) begin
                  // Abandon without ever asserting the stop state
                  state <= PMC_SEQ_IDLE;
                  seq.abort <= 1'b1;
               end else if (cnt == '0) begin
                  state <= PMC_SEQ_STOPPED;
                  seq.done <= 1'b1;
                  seq.active <= 1'b1;
               end else begin
                  cnt <= cnt - 1'b1;
               end
            end
            PMC_SEQ_STOPPED: begin
               if (wake_request) begin
                  state <= PMC_SEQ_IDLE;
                  seq.active <= 1'b0;
               end
            end
            default: begin
               state <= PMC_SEQ_IDLE;
               seq.active <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_abort_no_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == PMC_SEQ_ENTER && wake_request) |=> (!seq.active && !seq.done)[*2])
      else $error("stop entered after abort");
   a_deep_only: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == PMC_SEQ_IDLE && sleep_req && !deep_sleep_select) |=>
      (state == PMC_SEQ_IDLE && !seq.start))
      else $error("sequence started without deep sleep");
   a_entry_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      seq.start |-> seq.mode == $past(stop_mode_select))
      else $error("stop mode not taken from selection");
   // Cycles since the entry started; kept apart from cnt so the check does not trust it
   int unsigned entry_age;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         entry_age <= '0;
      end else if (seq.start) begin
         entry_age <= 32'd1;
      end else if (seq.done || seq.abort) begin
         entry_age <= '0;
      end else if (entry_age != '0) begin
         entry_age <= entry_age + 32'd1;
      end
   end

   a_entry_time: assert property (@(posedge aclk) disable iff (!aresetn)
      seq.done |-> entry_age == ENTRY_CYCLES)
      else $error("stop entry took wrong time");

endmodule
`default_nettype wire

// ### logic/pmc_top.sv
// Power mode control block: register file over AXI4-Lite and stop entry status
// Notes on behaviour
// - Run 10 very low power; 01, 11 reserved
// - Control bit 4 always reads zero
// - Interrupt or reset during entry sets aborted flag
// - Aborted entry never reaches the stop mode
// - Each entry start clears the aborted flag
// - Stop select decides mode entered on sleep
// - Run select 00 means normal run
// - Run writes ignored unless protection permits mode
// - Stop mode only on deep sleep requests
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

module pmc_top
   import pmc_pkg::*;
#(
   parameter int ENTRY_CYCLES = `PMC_ENTRY_CYCLES,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core sleep interface
   input wire logic sleep_req,
   input wire logic deep_sleep_select,
   input wire logic wake_request,
   // Power state outputs
   output logic stop_active,
   output logic [2:0] stop_mode_entered,
   output logic [1:0] run_mode,
   output logic irq
);

   pmc_seq_status_type seq;
   logic [7:0] prot;
   logic prot_written;
   logic [2:0] stop_mode;
   logic aborted;
   logic [7:0] mode_state;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic aw_held;
   logic w_held;
   logic [5:0] aw_idx;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic rd_ctrl;
   logic do_write;
   logic wr_ctrl;
   logic [1:0] next_run;
   logic [2:0] next_stop;
   logic [7:0] ctrl_value;
   logic [5:0] ar_idx;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_ctrl = do_write && wstrb0_q && aw_idx == `PMC_IDX_CTRL;
   assign next_run = wdata_q[`PMC_RUN_MODE_SELECT_HI:`PMC_RUN_MODE_SELECT_LO];
   assign next_stop = wdata_q[`PMC_STOP_MODE_SELECT_HI:`PMC_STOP_MODE_SELECT_LO];
   assign ar_idx = s_axi_araddr[7:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMC_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
      end else begin
         if (!aw_held && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (!w_held && !s_axi_wready && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_idx == `PMC_IDX_PROT || aw_idx == `PMC_IDX_CTRL ||
               aw_idx == `PMC_IDX_STATE || aw_idx == `PMC_IDX_IRQ_STAT ||
               aw_idx == `PMC_IDX_IRQ_MASK) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Protection and control fields
   // ----------------------------------------------------------------
   // Protection takes only its first write with byte lane 0 enabled after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot <= `PMC_PROT_RESET;
         prot_written <= 1'b0;
      end else if (do_write && wstrb0_q && aw_idx == `PMC_IDX_PROT && !prot_written) begin
         prot <= wdata_q[7:0] & ((8'h01 << `PMC_PROT_AVLP) | (8'h01 << `PMC_PROT_AVLLS));
         prot_written <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_mode <= `PMC_RUN_MODE_SELECT_RESET;
      end else if (wr_ctrl) begin
         if (next_run == `PMC_RUN_NORMAL) begin
            run_mode <= `PMC_RUN_NORMAL;
         end else if (next_run == `PMC_RUN_VERY_LOW_POWER_RUN && prot[`PMC_PROT_AVLP]) begin
            run_mode <= `PMC_RUN_VERY_LOW_POWER_RUN;
         end
      end
   end

   // A stop mode that protection does not permit leaves the selection unchanged
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_mode <= `PMC_STOP_MODE_SELECT_RESET;
      end else if (wr_ctrl) begin
         if (next_stop == `PMC_STOP_NORMAL ||
            (next_stop == `PMC_STOP_VLPS && prot[`PMC_PROT_AVLP]) ||
            (next_stop == `PMC_STOP_VLLS && prot[`PMC_PROT_AVLLS])) begin
            stop_mode <= next_stop;
         end
      end
   end

   // Only the sequencer moves this flag; bus writes never reach it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aborted <= 1'b0;
      end else if (seq.abort) begin
         aborted <= 1'b1;
      end else if (seq.start) begin
         aborted <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_state <= `PMC_STATE_RUN;
      end else if (seq.active) begin
         mode_state <= `PMC_STATE_STOP;
      end else begin
         mode_state <= (run_mode == `PMC_RUN_VERY_LOW_POWER_RUN) ? `PMC_STATE_VERY_LOW_POWER_RUN : `PMC_STATE_RUN;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   // A new event beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 2'h0;
         irq_mask <= 2'h0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~((do_write && wstrb0_q &&
            aw_idx == `PMC_IDX_IRQ_STAT) ? wdata_q[1:0] : 2'h0)) |
            {seq.abort, seq.done};
         if (do_write && wstrb0_q && aw_idx == `PMC_IDX_IRQ_MASK) begin
            irq_mask <= wdata_q[1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   assign ctrl_value = {1'b0, run_mode, 1'b0, aborted, stop_mode};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PMC_RESP_OKAY;
         rd_ctrl <= 1'b0;
      end else begin
         if (!s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PMC_RESP_OKAY;
            rd_ctrl <= (ar_idx == `PMC_IDX_CTRL);
            case (ar_idx)
               `PMC_IDX_PROT: s_axi_rdata <= {24'h00_0000, prot};
               `PMC_IDX_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_value};
               `PMC_IDX_STATE: s_axi_rdata <= {24'h00_0000, mode_state};
               `PMC_IDX_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_status};
               `PMC_IDX_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `PMC_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Stop entry sequencer
   // ----------------------------------------------------------------
   pmc_stop_seq #(
      .ENTRY_CYCLES(ENTRY_CYCLES)
   ) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .sleep_req(sleep_req),
      .deep_sleep_select(deep_sleep_select),
      .wake_request(wake_request),
      .stop_mode_select(stop_mode),
      .seq(seq)
   );

   assign stop_active = seq.active;
   assign stop_mode_entered = seq.mode;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_rsvd_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && rd_ctrl) |-> !s_axi_rdata[`PMC_RSVD_BIT])
      else $error("reserved control bit read as one");
   a_run_mode_select_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_ctrl && next_run[0]) |=> $stable(run_mode))
      else $error("reserved run encoding accepted");
   a_run_mode_select_very_low_power_run: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_ctrl && next_run == `PMC_RUN_VERY_LOW_POWER_RUN && prot[`PMC_PROT_AVLP]) |=>
      run_mode == `PMC_RUN_VERY_LOW_POWER_RUN ##1 mode_state == `PMC_STATE_VERY_LOW_POWER_RUN || seq.active)
      else $error("permitted very low power run not taken");
   a_run_mode_select_normal: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_ctrl && next_run == `PMC_RUN_NORMAL) |=> run_mode == `PMC_RUN_NORMAL)
      else $error("normal run not taken");
   a_run_mode_select_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_ctrl && next_run == `PMC_RUN_VERY_LOW_POWER_RUN && !prot[`PMC_PROT_AVLP]) |=> $stable(run_mode))
      else $error("run write not blocked by protection");
   a_abort_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      seq.abort |=> aborted && irq_status[`PMC_IRQ_ABORT])
      else $error("abort not recorded");
   a_start_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      (seq.start && !seq.abort) |=> !aborted)
      else $error("aborted flag not cleared at entry start");
   a_abort_ro: assert property (@(posedge aclk) disable iff (!aresetn)
      (!seq.start && !seq.abort) |=> $stable(aborted))
      else $error("aborted flag changed without sequencer");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 irq == $past(|(irq_status & irq_mask)))
      else $error("interrupt output wrong");

endmodule
`default_nettype wire

// ### sim/pmc_core_model.sv
// Processor core model that issues sleep and wake requests
`timescale 1ns/1ps
`default_nettype none

module pmc_core_model (
   // Clock
   input wire logic aclk,
   // Sleep request side
   output logic sleep_req,
   output logic deep_sleep_select,
   output logic wake_request
);
   initial begin
      sleep_req = 1'b0;
      deep_sleep_select = 1'b0;
      wake_request = 1'b0;
   end

   // One-cycle request, as a sleep instruction gives; the qualifier drops with it
   task automatic request_sleep(input logic deep);
      @(posedge aclk);
      sleep_req <= 1'b1;
      deep_sleep_select <= deep;
      @(posedge aclk);
      sleep_req <= 1'b0;
      deep_sleep_select <= 1'b0;
   endtask

   // A pending interrupt or reset, held for a single cycle only
   task automatic raise_wake();
      @(posedge aclk);
      wake_request <= 1'b1;
      @(posedge aclk);
      wake_request <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ### sim/tb_power_mode_control_status.sv
// Self-checking bench for the power mode control block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

module tb_power_mode_control_status
   import pmc_pkg::*;
;
   // ------------
   // Signals
   // ------------
   localparam int ENTRY = 12;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sleep_req, deep_sleep_select;
   logic wake_request, stop_active, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, run_mode, resp;
   logic [2:0] stop_mode_entered;
   int fails, total_checks;

   pmc_top #(.ENTRY_CYCLES(ENTRY), .ADDR_W(8)) i_pmc_top (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_req(sleep_req),
      .deep_sleep_select(deep_sleep_select), .wake_request(wake_request),
      .stop_active(stop_active), .stop_mode_entered(stop_mode_entered),
      .run_mode(run_mode), .irq(irq)
   );

   pmc_core_model i_pmc_core_model (
      .aclk(aclk), .sleep_req(sleep_req),
      .deep_sleep_select(deep_sleep_select), .wake_request(wake_request)
   );

   // ------------
   // Tasks
   // ------------
   task automatic final_report();
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic guard(input int n);
      if (n > ENTRY + 40) begin
         check("wait_bound", 32'h0000_0000, 32'h0000_0001);
         final_report();
      end
   endtask

   task automatic axi_write(input logic [5:0] idx, input logic [7:0] val);
      int n;
      logic a, w;
      n = 0;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      awvalid <= 1'b1;
      wdata <= {24'h00_0000, val};
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (!a && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
         n++;
         guard(n);
      end
      do begin
         @(posedge aclk);
         n++;
         guard(n);
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [5:0] idx);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         guard(n);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         n++;
         guard(n);
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic read_check(input string name, input logic [5:0] idx, input logic [7:0] exp);
      axi_read(idx);
      check(name, rd, {24'h00_0000, exp});
   endtask

   task automatic wait_stop(input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         guard(n);
      end while (stop_active !== lvl);
   endtask

   // Interrupt output lags its status by a cycle
   task automatic check_irq(input logic exp);
      repeat (2) @(posedge aclk);
      check("irq", 32'(irq), 32'(exp));
   endtask

   // ------------
   // Scenarios
   // ------------
   task automatic t_reset();
      read_check("ctrl_reset", `PMC_IDX_CTRL, 8'h00);
      read_check("state_reset", `PMC_IDX_STATE, `PMC_STATE_RUN);
      check("run_reset", 32'(run_mode), 32'(`PMC_RUN_NORMAL));
   endtask

   task automatic t_protect();
      // A write without lane 0 must not use up the single protection write
      wstrb <= 4'he;
      axi_write(`PMC_IDX_PROT, 8'h22);
      wstrb <= 4'hf;
      read_check("prot_no_lane", `PMC_IDX_PROT, 8'h00);
      axi_write(`PMC_IDX_CTRL, 8'h42);
      read_check("ctrl_unprot", `PMC_IDX_CTRL, 8'h00);
      check("run_unprot", 32'(run_mode), 32'(`PMC_RUN_NORMAL));
      axi_write(6'h02, 8'hff);
      check("bresp_unmapped", 32'(resp), 32'(`PMC_RESP_SLVERR));
      read_check("rdata_unmapped", 6'h02, 8'h00);
      check("rresp_unmapped", 32'(resp), 32'(`PMC_RESP_SLVERR));
      axi_write(`PMC_IDX_PROT, 8'h22);
      check("bresp_okay", 32'(resp), 32'(`PMC_RESP_OKAY));
      axi_write(`PMC_IDX_PROT, 8'h00);
      read_check("prot_once", `PMC_IDX_PROT, 8'h22);
   endtask

   task automatic t_run();
      int n;
      axi_write(`PMC_IDX_CTRL, 8'h20);
      check("run_rsvd1", 32'(run_mode), 32'(`PMC_RUN_NORMAL));
      axi_write(`PMC_IDX_CTRL, 8'h60);
      check("run_rsvd3", 32'(run_mode), 32'(`PMC_RUN_NORMAL));
      axi_write(`PMC_IDX_CTRL, 8'h18);
      read_check("ctrl_ro_bits", `PMC_IDX_CTRL, 8'h00);
      // Very low power run is chosen here from normal run, with AVLP set by the protection write
      axi_write(`PMC_IDX_CTRL, 8'h40);
      check("run_very_low_power_run", 32'(run_mode), 32'(`PMC_RUN_VERY_LOW_POWER_RUN));
      n = 0;
      do begin
         axi_read(`PMC_IDX_STATE);
         n++;
         guard(n);
      end while (rd[7:0] !== `PMC_STATE_VERY_LOW_POWER_RUN);
      axi_write(`PMC_IDX_CTRL, 8'h00);
      check("run_normal", 32'(run_mode), 32'(`PMC_RUN_NORMAL));
   endtask

   task automatic t_stop();
      logic [2:0] modes[3];
      modes = '{`PMC_STOP_NORMAL, `PMC_STOP_VLPS, `PMC_STOP_VLLS};
      axi_write(`PMC_IDX_IRQ_MASK, 8'h03);
      foreach (modes[i]) begin
         axi_write(`PMC_IDX_CTRL, {5'h00, modes[i]});
         read_check("ctrl_stop_mode_select", `PMC_IDX_CTRL, {5'h00, modes[i]});
         i_pmc_core_model.request_sleep(1'b0);
         repeat (ENTRY + 4) @(posedge aclk);
         check("shallow_sleep", 32'(stop_active), 32'h0000_0000);
         i_pmc_core_model.request_sleep(1'b1);
         wait_stop(1'b1);
         check("mode_entered", 32'(stop_mode_entered), 32'(modes[i]));
         read_check("state_stop", `PMC_IDX_STATE, `PMC_STATE_STOP);
         read_check("irq_done", `PMC_IDX_IRQ_STAT, 8'h01);
         check_irq(1'b1);
         axi_write(`PMC_IDX_IRQ_STAT, 8'h01);
         check_irq(1'b0);
         i_pmc_core_model.raise_wake();
         wait_stop(1'b0);
      end
   endtask

   task automatic t_abort();
      axi_write(`PMC_IDX_CTRL, 8'h02);
      i_pmc_core_model.request_sleep(1'b1);
      repeat (3) @(posedge aclk);
      i_pmc_core_model.raise_wake();
      repeat (ENTRY + 4) @(posedge aclk);
      check("abort_no_stop", 32'(stop_active), 32'h0000_0000);
      read_check("abort_flag", `PMC_IDX_CTRL, 8'h0a);
      read_check("irq_abort", `PMC_IDX_IRQ_STAT, 8'h02);
      check_irq(1'b1);
      // Writing zero over the set flag must leave it standing
      axi_write(`PMC_IDX_CTRL, 8'h02);
      read_check("flag_kept", `PMC_IDX_CTRL, 8'h0a);
      axi_write(`PMC_IDX_IRQ_STAT, 8'h02);
      check_irq(1'b0);
      // Read lands inside the entry window, well before completion
      i_pmc_core_model.request_sleep(1'b1);
      repeat (3) @(posedge aclk);
      read_check("flag_cleared", `PMC_IDX_CTRL, 8'h02);
      check("still_entering", 32'(stop_active), 32'h0000_0000);
      wait_stop(1'b1);
      i_pmc_core_model.raise_wake();
      wait_stop(1'b0);
   endtask

   // ------------
   // Main
   // ------------
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      fails = 0;
      total_checks = 0;
      aresetn = 1'b0;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_protect();
      t_run();
      t_stop();
      t_abort();
      final_report();
   end
endmodule

`default_nettype wire
